// *** include/pmtb_regs.svh ***
// Register offsets, write masks, reset values and timing figures of the
// PWM master time base. Included by the core and by the testbench.
`ifndef PMTB_REGS_SVH
`define PMTB_REGS_SVH

`define PMTB_OFF_CTRL 8'h00
`define PMTB_OFF_CLKDIV 8'h04
`define PMTB_OFF_PERIOD 8'h08
`define PMTB_OFF_SEVCMP 8'h0c
`define PMTB_OFF_MDUTY 8'h10
`define PMTB_OFF_TBCNT 8'h14
`define PMTB_OFF_GEN0 8'h20
`define PMTB_GEN_STRIDE 8'h04

`define PMTB_CTRL_WMASK 16'hafbf
`define PMTB_CTRL_RESET 16'h0000
`define PMTB_PERIOD_RESET 16'hfff8
`define PMTB_SEVCMP_MASK 16'hfff8
`define PMTB_SEVCMP_RESET 16'h0000
`define PMTB_MDUTY_RESET 16'h0000
`define PMTB_CLKDIV_RESET 3'h0
`define PMTB_CLKDIV_RSVD 3'h7
`define PMTB_GEN_RESET 19'h00000

`define PMTB_RESP_OKAY 2'h0
`define PMTB_RESP_SLVERR 2'h2

`define PMTB_RES_PS 1040
`define PMTB_RES_CA_PS 8320
`define PMTB_CA_STEP (`PMTB_RES_CA_PS / `PMTB_RES_PS)

`endif

// *** include/pmtb_pkg.sv ***
// Types of the PWM master time base: control word layout, generator
// configuration and sync source codes. Offsets live in pmtb_regs.svh.
package pmtb_pkg;

    typedef enum logic [1:0] {
        PMTB_SRC_IN1 = 2'b00,
        PMTB_SRC_IN2 = 2'b01,
        PMTB_SRC_RSV2 = 2'b10,
        PMTB_SRC_RSV3 = 2'b11
    } pmtb_sync_src_e;

    typedef struct packed {
        logic pwm_module_on;
        logic unimp14;
        logic idle_halt_select;
        logic special_event_pending;
        logic special_event_irq_on;
        logic immediate_period_load;
        logic sync_polarity_invert;
        logic sync_out_on;
        logic ext_sync_on;
        logic unimp6;
        pmtb_sync_src_e sync_source_select;
        logic [3:0] special_event_postscale;
    } pmtb_ctrl_s;

    typedef struct packed {
        logic center_aligned;
        logic variable_phase;
        logic push_pull;
        logic [15:0] phase;
    } pmtb_gen_s;

endpackage : pmtb_pkg

// *** core/pmtb_core.sv ***
// PWM master time base with four generators, AXI4-Lite register slave.
// Assumes a single 10 MHz clock, synchronous sync inputs and an interrupt
// controller that acknowledges the special event with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "pmtb_regs.svh"

module pmtb_core (
    input wire logic aclk, // System clock, 10 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic cpu_idle, // CPU is in idle mode.
    input wire logic [1:0] sync_input, // External sync inputs one and two.
    input wire logic special_event_ack, // Interrupt controller took the event.
    output logic sync_output, // Period sync pulse.
    output logic sync_output_en_n, // Sync output driver enable, low drives.
    output logic special_event_trigger, // Postscaled compare trigger pulse.
    output logic special_event_irq, // Special event interrupt request.
    output logic [3:0] high_side_output, // Generator high-side outputs.
    output logic [3:0] low_side_output // Generator low-side outputs.
);

    function automatic logic is_gen(input logic [7:0] a);
        is_gen = (a >= `PMTB_OFF_GEN0) && (a < `PMTB_OFF_GEN0 + 4 * `PMTB_GEN_STRIDE);
    endfunction : is_gen

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `PMTB_OFF_CTRL) || (a == `PMTB_OFF_CLKDIV)
            || (a == `PMTB_OFF_PERIOD) || (a == `PMTB_OFF_SEVCMP)
            || (a == `PMTB_OFF_MDUTY) || (a == `PMTB_OFF_TBCNT) || is_gen(a);
    endfunction : is_mapped

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // Register file and bus state.
    pmtb_pkg::pmtb_ctrl_s ctrl_reg, ctrl_next;
    logic [2:0] clkdiv_reg, clkdiv_next;
    logic [15:0] period_reg, period_next;
    logic [15:0] sevcmp_reg, sevcmp_next;
    logic [15:0] mduty_reg, mduty_next;
    pmtb_pkg::pmtb_gen_s gen_reg [4];
    pmtb_pkg::pmtb_gen_s gen_next [4];
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
    logic [1:0] bresp_next, rresp_next;
    logic [31:0] rdata_next;

    // Time base state.
    logic [5:0] presc_reg, presc_next;
    logic [15:0] tb_reg, tb_next;
    logic [15:0] active_per_reg, active_per_next;
    logic [3:0] ps_cnt_reg, ps_cnt_next;
    logic [3:0] pp_reg, pp_next;
    logic sync_prev_reg, sync_prev_next;
    logic sev_fire, run, tick, wrap, match, sync_lvl, sync_edge;
    logic [5:0] div_mask;
    logic [3:0] hs_next, ls_next;
    logic sync_out_next, sync_oe_n_next, trig_next, irq_next;

    always_comb begin
        logic do_wr;
        logic [31:0] rd;
        integer g;
        do_wr = 1'b0;
        rd = 32'h0000_0000;
        g = 0;
        ctrl_next = ctrl_reg;
        clkdiv_next = clkdiv_reg;
        period_next = period_reg;
        sevcmp_next = sevcmp_reg;
        mduty_next = mduty_reg;
        gen_next = gen_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = s_axi_bvalid;
        bresp_next = s_axi_bresp;
        rvalid_next = s_axi_rvalid;
        rresp_next = s_axi_rresp;
        rdata_next = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
            do_wr = 1'b1;
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = is_mapped(aw_addr_reg) ? `PMTB_RESP_OKAY : `PMTB_RESP_SLVERR;
        end
        if (do_wr) begin
            case (aw_addr_reg)
                `PMTB_OFF_CTRL: begin
                    // Hardware alone owns the pending bit; reserved bits stay zero.
                    ctrl_next = (merge16(ctrl_reg, w_data_reg, w_strb_reg) & `PMTB_CTRL_WMASK)
                        | (ctrl_reg & ~`PMTB_CTRL_WMASK);
                end
                `PMTB_OFF_CLKDIV: if (w_strb_reg[0]) clkdiv_next = w_data_reg[2:0];
                `PMTB_OFF_PERIOD: period_next = merge16(period_reg, w_data_reg, w_strb_reg);
                `PMTB_OFF_SEVCMP: begin
                    sevcmp_next = merge16(sevcmp_reg, w_data_reg, w_strb_reg)
                        & `PMTB_SEVCMP_MASK;
                end
                `PMTB_OFF_MDUTY: mduty_next = merge16(mduty_reg, w_data_reg, w_strb_reg);
                default: begin
                    if (is_gen(aw_addr_reg)) begin
                        g = 32'(aw_addr_reg - `PMTB_OFF_GEN0) / 4;
                        gen_next[g][15:0] = merge16(gen_reg[g][15:0], w_data_reg, w_strb_reg);
                        if (w_strb_reg[2]) gen_next[g][18:16] = w_data_reg[18:16];
                    end
                end
            endcase
        end
        // Pending is set by the postscaler and dropped on acknowledge; set wins.
        if (special_event_ack) ctrl_next.special_event_pending = 1'b0;
        if (sev_fire) ctrl_next.special_event_pending = 1'b1;
        if (s_axi_rvalid && s_axi_rready) rvalid_next = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            case (s_axi_araddr)
                `PMTB_OFF_CTRL: rd = {16'h0000, ctrl_reg};
                `PMTB_OFF_CLKDIV: rd = {29'h0000_0000, clkdiv_reg};
                `PMTB_OFF_PERIOD: rd = {16'h0000, period_reg};
                `PMTB_OFF_SEVCMP: rd = {16'h0000, sevcmp_reg};
                `PMTB_OFF_MDUTY: rd = {16'h0000, mduty_reg};
                `PMTB_OFF_TBCNT: rd = {16'h0000, tb_reg};
                default: begin
                    if (is_gen(s_axi_araddr)) begin
                        rd = {13'h0000, gen_reg[32'(s_axi_araddr - `PMTB_OFF_GEN0) / 4]};
                    end
                end
            endcase
            rvalid_next = 1'b1;
            rdata_next = rd;
            rresp_next = is_mapped(s_axi_araddr) ? `PMTB_RESP_OKAY : `PMTB_RESP_SLVERR;
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `PMTB_CTRL_RESET;
            clkdiv_reg <= `PMTB_CLKDIV_RESET;
            period_reg <= `PMTB_PERIOD_RESET;
            sevcmp_reg <= `PMTB_SEVCMP_RESET;
            mduty_reg <= `PMTB_MDUTY_RESET;
            for (int i = 0; i < 4; i++) gen_reg[i] <= `PMTB_GEN_RESET;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            clkdiv_reg <= clkdiv_next;
            period_reg <= period_next;
            sevcmp_reg <= sevcmp_next;
            mduty_reg <= mduty_next;
            gen_reg <= gen_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            s_axi_awready <= awready_next;
            s_axi_wready <= wready_next;
            s_axi_bvalid <= bvalid_next;
            s_axi_bresp <= bresp_next;
            s_axi_arready <= arready_next;
            s_axi_rvalid <= rvalid_next;
            s_axi_rresp <= rresp_next;
            s_axi_rdata <= rdata_next;
        end
    end

    // Time base. One count is one step of timing resolution; the 1.04 ns figure
    // holds for the full-speed core clock, here a step is one prescaled clock.
    always_comb begin
        logic [15:0] loc, duty;
        logic on;
        loc = 16'h0000;
        duty = 16'h0000;
        on = 1'b0;
        run = ctrl_reg.pwm_module_on
            && !(cpu_idle && ctrl_reg.idle_halt_select);
        // A reserved divider code falls back to divide by one.
        div_mask = (clkdiv_reg == `PMTB_CLKDIV_RSVD) ? 6'h00
            : 6'((7'h01 << clkdiv_reg) - 7'h01);
        tick = run && (presc_reg == div_mask);
        wrap = tick && (tb_reg >= active_per_reg);
        match = tick && (tb_reg == sevcmp_reg);
        sev_fire = match && (ps_cnt_reg == ctrl_reg.special_event_postscale);
        case (ctrl_reg.sync_source_select)
            pmtb_pkg::PMTB_SRC_IN1: sync_lvl = sync_input[0] ^ ctrl_reg.sync_polarity_invert;
            pmtb_pkg::PMTB_SRC_IN2: sync_lvl = sync_input[1] ^ ctrl_reg.sync_polarity_invert;
            default: sync_lvl = 1'b0;
        endcase
        sync_prev_next = sync_lvl;
        sync_edge = ctrl_reg.ext_sync_on && sync_lvl && !sync_prev_reg;
        presc_next = (!run || tick) ? 6'h00 : presc_reg + 6'h01;
        tb_next = tb_reg;
        if (!ctrl_reg.pwm_module_on) tb_next = 16'h0000;
        else if (run && sync_edge) tb_next = 16'h0000;
        else if (wrap) tb_next = 16'h0000;
        else if (tick) tb_next = tb_reg + 16'h0001;
        active_per_next = active_per_reg;
        if (ctrl_reg.immediate_period_load || wrap || !ctrl_reg.pwm_module_on) begin
            active_per_next = period_reg;
        end
        ps_cnt_next = ps_cnt_reg;
        if (!ctrl_reg.pwm_module_on || sev_fire) ps_cnt_next = 4'h0;
        else if (match) ps_cnt_next = ps_cnt_reg + 4'h1;
        pp_next = ctrl_reg.pwm_module_on ? (wrap ? ~pp_reg : pp_reg) : 4'h0;
        for (int g = 0; g < 4; g++) begin
            loc = tb_reg + gen_reg[g].phase;
            if (loc >= active_per_reg) loc = loc - active_per_reg;
            duty = gen_reg[g].variable_phase ? (active_per_reg >> 1) : mduty_reg;
            if (gen_reg[g].center_aligned) begin
                loc = loc & ~16'(`PMTB_CA_STEP - 1);
                duty = duty & ~16'(`PMTB_CA_STEP - 1);
            end
            on = loc < duty;
            if (!ctrl_reg.pwm_module_on) begin
                hs_next[g] = 1'b0;
                ls_next[g] = 1'b0;
            end else if (gen_reg[g].push_pull) begin
                hs_next[g] = on && !pp_reg[g];
                ls_next[g] = on && pp_reg[g];
            end else begin
                hs_next[g] = on;
                ls_next[g] = !on;
            end
        end
        sync_out_next = (ctrl_reg.sync_out_on && wrap) ^ ctrl_reg.sync_polarity_invert;
        sync_oe_n_next = !ctrl_reg.sync_out_on;
        trig_next = sev_fire;
        irq_next = ctrl_reg.special_event_pending && ctrl_reg.special_event_irq_on;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_reg <= 6'h00;
            tb_reg <= 16'h0000;
            active_per_reg <= `PMTB_PERIOD_RESET;
            ps_cnt_reg <= 4'h0;
            pp_reg <= 4'h0;
            sync_prev_reg <= 1'b0;
            high_side_output <= 4'h0;
            low_side_output <= 4'h0;
            sync_output <= 1'b0;
            sync_output_en_n <= 1'b1;
            special_event_trigger <= 1'b0;
            special_event_irq <= 1'b0;
        end else begin
            presc_reg <= presc_next;
            tb_reg <= tb_next;
            active_per_reg <= active_per_next;
            ps_cnt_reg <= ps_cnt_next;
            pp_reg <= pp_next;
            sync_prev_reg <= sync_prev_next;
            high_side_output <= hs_next;
            low_side_output <= ls_next;
            sync_output <= sync_out_next;
            sync_output_en_n <= sync_oe_n_next;
            special_event_trigger <= trig_next;
            special_event_irq <= irq_next;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence fire_s;
        sev_fire;
    endsequence
    sequence pending_s;
        ctrl_reg.special_event_pending ##1 special_event_irq == $past(ctrl_reg.special_event_irq_on);
    endsequence

    off_outputs_a: assert property (!ctrl_reg.pwm_module_on |=> high_side_output == 4'h0
        && low_side_output == 4'h0) else $error("outputs active while off");
    idle_halt_a: assert property (cpu_idle && ctrl_reg.idle_halt_select
        && ctrl_reg.pwm_module_on |=> $stable(tb_reg)) else $error("time base ran in idle");
    pend_set_a: assert property (fire_s |=> pending_s)
        else $error("pending or request wrong after trigger");
    trig_pulse_a: assert property (fire_s |=> special_event_trigger ##1 !special_event_trigger
        || $past(sev_fire)) else $error("trigger pulse wrong");
    imm_load_a: assert property (ctrl_reg.immediate_period_load |=>
        active_per_reg == $past(period_reg)) else $error("immediate load missed");
    defer_load_a: assert property (ctrl_reg.pwm_module_on && !ctrl_reg.immediate_period_load
        && !wrap |=> $stable(active_per_reg)) else $error("period loaded mid cycle");
    sync_gate_a: assert property (!ctrl_reg.sync_out_on |=> sync_output_en_n)
        else $error("sync output driven while off");
    wrap_zero_a: assert property (wrap && !sync_edge |=> tb_reg == 16'h0000 ##1
        (tb_reg <= 16'h0001)) else $error("time base did not restart");
    sync_restart_a: assert property (run && sync_edge |=> tb_reg == 16'h0000)
        else $error("external sync ignored");
    unimp_zero_a: assert property (ctrl_reg.unimp14 == 1'b0 && ctrl_reg.unimp6 == 1'b0)
        else $error("unimplemented control bit set");

endmodule : pmtb_core
`default_nettype wire

// *** verification/pmtb_sync_src.sv ***
// External sync source model: a one-cycle active pulse on the chosen line.
// Assumes the bench sets its controls only while run is low.
`timescale 1ns/1ps
`default_nettype none
module pmtb_sync_src (
    input wire logic aclk, // Bench clock.
    input wire logic run, // Pulse train on.
    input wire logic line, // Line that pulses.
    input wire logic inv, // Active-low pulses when high.
    input wire logic [7:0] every, // Pulse spacing in cycles.
    output logic [1:0] sync_input // Lines to the block.
);
    logic [7:0] cnt_reg;
    always_ff @(posedge aclk) begin
        if (!run) begin
            cnt_reg <= 8'h00;
            sync_input <= {2{inv}};
        end else begin
            cnt_reg <= (cnt_reg == every - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
            sync_input <= {2{inv}};
            sync_input[line] <= (cnt_reg == 8'h00) ? ~inv : inv;
        end
    end
endmodule : pmtb_sync_src
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the PWM master time base over AXI4-Lite.
// Assumes the core's register map and one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "pmtb_regs.svh"
module testbench;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0] aa = 0, ra = 0, every = 8'h20;
    logic [31:0] wd = 0, rd;
    logic [1:0] rsp, si;
    logic idle = 0, ack = 0, run = 0, line = 0;
    logic awr, wr_rdy, bv, arr, rv, so, so_en_n, trig, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] hs, ls;
    int miscompares = 0, cmp_count = 0;
    initial forever #50 aclk = ~aclk;
    pmtb_sync_src src_u (.aclk(aclk), .run(run), .line(line), .inv(1'b0), .every(every),
        .sync_input(si));
    pmtb_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .cpu_idle(idle),
        .sync_input(si), .special_event_ack(ack), .sync_output(so),
        .sync_output_en_n(so_en_n), .special_event_trigger(trig),
        .special_event_irq(irq), .high_side_output(hs), .low_side_output(ls));
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task hang;
        miscompares++;
        tally_and_finish;
    endtask : hang
    task wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        logic ad, dd;
        ad = 0;
        dd = 0;
        aa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (ad && dd && bv === 1'b1) break;
            if (!ad && awr === 1'b1) begin ad = 1; awv <= 0; end
            if (!dd && wr_rdy === 1'b1) begin dd = 1; wv <= 0; end
        end
        if (i == 60) hang;
        rsp = bresp;
    endtask : wr
    task rdr(input logic [7:0] a);
        int i;
        logic ad;
        ad = 0;
        ra <= a; arv <= 1; rr <= 1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (ad && rv === 1'b1) break;
            if (!ad && arr === 1'b1) begin ad = 1; arv <= 0; end
        end
        if (i == 60) hang;
        rd = rdata; rsp = rresp;
    endtask : rdr
    task cfg(input logic [15:0] v);
        wr(`PMTB_OFF_CTRL, 32'h0);
        wr(`PMTB_OFF_CTRL, {16'h0, v & 16'h7fff});
        wr(`PMTB_OFF_CTRL, {16'h0, v});
    endtask : cfg
    // Cycles between two active cycles of sync_output (t=0) or trigger (t=1).
    task gap(input logic t, input logic lvl, output int g);
        int n, f;
        f = -1;
        g = -1;
        for (n = 0; n < 2000 && g < 0; n++) begin
            @(posedge aclk);
            #1;
            if ((t ? trig : so) === lvl) begin
                if (f < 0) f = n;
                else g = n - f;
            end
        end
        if (g < 0) hang;
        // Realign to the rising edge so the next request starts on it.
        @(posedge aclk);
    endtask : gap
    task cnt(input int cyc, output int k);
        k = 0;
        repeat (cyc) begin
            @(posedge aclk);
            #1;
            if (so === 1'b1) k++;
        end
        @(posedge aclk);
    endtask : cnt
    task pins(input int g, output int h, output int l);
        h = 0;
        l = 0;
        repeat (68) begin
            @(posedge aclk);
            #1;
            if (hs[g] === 1'b1) h++;
            if (ls[g] === 1'b1) l++;
        end
        @(posedge aclk);
    endtask : pins
    task t_reset;
        rdr(`PMTB_OFF_CTRL); chk(rd, 32'h0);
        rdr(`PMTB_OFF_PERIOD); chk(rd, 32'hfff8);
        rdr(`PMTB_OFF_CLKDIV); chk(rd, 32'h0);
        rdr(8'h80); chk(rsp, 2'h2);
        wr(8'h84, 32'h1); chk(rsp, 2'h2);
        wr(`PMTB_OFF_CTRL, 32'h7fff); chk(rsp, 2'h0);
        rdr(`PMTB_OFF_CTRL); chk(rd, 32'h2fbf);
        wr(`PMTB_OFF_SEVCMP, 32'h000f);
        rdr(`PMTB_OFF_SEVCMP); chk(rd, 32'h0008);
    endtask : t_reset
    task t_period;
        int g, d;
        wr(`PMTB_OFF_PERIOD, 32'h0010);
        for (d = 0; d < 3; d++) begin
            wr(`PMTB_OFF_CTRL, 32'h0);
            wr(`PMTB_OFF_CLKDIV, d);
            cfg(16'h8100);
            chk(so_en_n, 1'b0);
            gap(1'b0, 1'b1, g);
            chk(g, 17 << d);
        end
        wr(`PMTB_OFF_CTRL, 32'h0);
        wr(`PMTB_OFF_CLKDIV, 32'h0);
        cfg(16'h8300);
        gap(1'b0, 1'b0, g);
        chk(g, 17);
        @(posedge aclk);
        #1;
        chk(so, 1'b1);
        @(posedge aclk);
    endtask : t_period
    task t_events;
        int g, k, ps;
        for (k = 0; k < 2; k++) begin
            ps = k ? 15 : 0;
            // Clear a pending event left by earlier runs so the set below is seen.
            wr(`PMTB_OFF_CTRL, 32'h0);
            ack <= 1;
            @(posedge aclk);
            ack <= 0;
            rdr(`PMTB_OFF_CTRL);
            chk(rd[12], 1'b0);
            cfg(16'h8100 | (k ? 16'h0 : 16'h0800) | 16'(ps));
            gap(1'b1, 1'b1, g);
            chk(g, (ps + 1) * 17);
            rdr(`PMTB_OFF_CTRL); chk(rd[12], 1'b1);
            chk(irq, !k);
            ack <= 1;
            @(posedge aclk);
            ack <= 0;
            repeat (3) @(posedge aclk);
            #1;
            chk(irq, 1'b0);
            @(posedge aclk);
        end
    endtask : t_events
    task t_idle;
        int k;
        cfg(16'h2100);
        cnt(100, k); chk(k, 0);
        cfg(16'h8000);
        cnt(100, k);
        chk(k, 0);
        chk(so_en_n, 1'b1);
        cfg(16'ha100);
        idle <= 1;
        repeat (2) @(posedge aclk);
        cnt(100, k); chk(k, 0);
        cfg(16'h8100);
        cnt(100, k); chk(k != 0, 1'b1);
        idle <= 0;
    endtask : t_idle
    task t_gen;
        int h, l;
        wr(`PMTB_OFF_CTRL, 32'h0);
        wr(`PMTB_OFF_PERIOD, 32'h0010);
        wr(`PMTB_OFF_MDUTY, 32'h0004);
        wr(`PMTB_OFF_GEN0 + 8'h04, 32'h0002_0000);
        wr(`PMTB_OFF_GEN0 + 8'h08, 32'h0001_0000);
        wr(`PMTB_OFF_GEN0 + 8'h0c, 32'h0004_0000);
        rdr(`PMTB_OFF_GEN0 + 8'h08);
        chk(rd, 32'h0001_0000);
        cfg(16'h8000);
        // Counts 0..16 fold onto 0..15, so a duty of d is on for d+1 of 17 cycles.
        pins(0, h, l);
        chk(h, 20);
        chk(l, 48);
        pins(1, h, l);
        chk(h, 36);
        chk(l, 32);
        pins(2, h, l);
        chk(h, 10);
        chk(l, 10);
        pins(3, h, l);
        chk(h, 0);
        chk(l, 68);
    endtask : t_gen
    task t_ext;
        int k, s;
        wr(`PMTB_OFF_CTRL, 32'h0);
        wr(`PMTB_OFF_PERIOD, 32'h0040);
        line <= 1;
        run <= 1;
        for (s = 0; s < 2; s++) begin
            cfg(16'h8180 | 16'(s << 4));
            cnt(300, k); chk(k == 0, s);
        end
    endtask : t_ext
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset;
        t_period;
        t_events;
        t_idle;
        t_gen;
        t_ext;
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
